// >>> flr_lanes.sv
// top of the multi-lane serial flash pin layer, device side
`timescale 1ns/1ps
module flr_lanes (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_lane_in,
    input wire flr_pkg::flr_mode_type i_xfer_mode,
    input wire logic i_in_wide,
    input wire logic i_out_phase,
    input wire logic i_quad_enable_bit,
    input wire logic [3:0] i_tx_data,
    output logic [3:0] o_lane_out,
    output logic [3:0] o_lane_oe_n,
    output logic o_rx_valid,
    output logic [3:0] o_rx_data,
    output logic o_tx_take,
    output logic o_write_protect,
    output logic o_hold_active,
    output logic o_selected
);
    // ********************************
    // reset release
    // ********************************
    logic [1:0] rst_sync_r;
    logic rst_n_r;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_r <= flr_pkg::FLR_RST_SYNC_RST;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n_r = rst_sync_r[1];

    // ********************************
    // pin synchroniser and lane map
    // ********************************
    flr_pins_if pins ();

    flr_pin_sync u_sync (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n_r),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_lane(i_lane_in),
        .pins(pins)
    );

    flr_pkg::flr_state_type state_r;
    flr_pkg::flr_state_type state_nxt;
    flr_pkg::flr_mode_type mode_r;
    flr_pkg::flr_mode_type mode_nxt;
    logic hold_r;
    logic hold_nxt;
    logic hold_req;
    logic [3:0] out_r;
    logic [3:0] out_nxt;
    logic [3:0] oe_r;
    logic [3:0] oe_nxt;
    logic rx_valid_r;
    logic rx_valid_nxt;
    logic [3:0] rx_data_r;
    logic [3:0] rx_data_nxt;
    logic tx_take_r;
    logic tx_take_nxt;
    logic wp_r;
    logic wp_nxt;
    logic sel_r;
    logic sel_nxt;
    logic [3:0] in_mask;
    logic [3:0] out_mask;
    logic [3:0] out_lanes;

    flr_lane_map u_map (
        .i_in_mode(i_xfer_mode),
        .i_in_wide(i_in_wide),
        .i_out_mode(mode_nxt),
        .i_tx_data(i_tx_data),
        .o_in_mask(in_mask),
        .o_out_mask(out_mask),
        .o_out_lanes(out_lanes)
    );

    // ********************************
    // transfer control
    // ********************************
    // hold pin and write-protect pin are pin functions only outside quad use
    assign hold_req = !pins.lane_in[3] && !i_quad_enable_bit
        && !flr_pkg::flr_is_quad(i_xfer_mode); // see (RULE4) see (RULE12)

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        hold_nxt = hold_r;
        out_nxt = out_r;
        rx_valid_nxt = 1'b0;
        rx_data_nxt = rx_data_r;
        tx_take_nxt = 1'b0;
        sel_nxt = !pins.cs_n; // see (RULE12)
        wp_nxt = !pins.lane_in[2] && !i_quad_enable_bit
            && !flr_pkg::flr_is_quad(i_xfer_mode); // see (RULE3) see (RULE13)
        if (pins.cs_n) begin
            state_nxt = flr_pkg::FLR_ST_IDLE; // see (RULE14)
            hold_nxt = 1'b0;
        end else begin
            if (!pins.sck_lvl) begin
                hold_nxt = hold_req; // see (RULE15)
            end
            case (state_r)
                flr_pkg::FLR_ST_IDLE: begin
                    state_nxt = flr_pkg::FLR_ST_IN;
                end
                flr_pkg::FLR_ST_IN: begin
                    if (pins.sck_fall && !hold_nxt && i_out_phase) begin
                        state_nxt = flr_pkg::FLR_ST_OUT; // see (RULE17)
                        mode_nxt = i_xfer_mode;
                    end
                end
                flr_pkg::FLR_ST_OUT: begin
                    if (pins.sck_fall && !hold_nxt && !i_out_phase) begin
                        state_nxt = flr_pkg::FLR_ST_IN; // see (RULE17)
                    end
                end
                default: begin
                    state_nxt = flr_pkg::FLR_ST_IDLE;
                end
            endcase
            if (state_r == flr_pkg::FLR_ST_IN && pins.sck_rise && !hold_r) begin
                rx_valid_nxt = 1'b1; // see (RULE10)
                rx_data_nxt = pins.lane_in & in_mask; // see (RULE1) see (RULE6)
            end
            if (state_nxt == flr_pkg::FLR_ST_OUT && pins.sck_fall && !hold_nxt) begin
                out_nxt = out_lanes; // see (RULE11) see (RULE2)
                tx_take_nxt = 1'b1;
            end
        end
        if (state_nxt == flr_pkg::FLR_ST_OUT && !hold_nxt) begin
            oe_nxt = ~out_mask; // see (RULE17) see (RULE7) see (RULE9)
        end else begin
            oe_nxt = flr_pkg::FLR_LANES_RELEASED; // see (RULE14) see (RULE15)
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= flr_pkg::FLR_ST_IDLE;
            mode_r <= flr_pkg::FLR_SINGLE;
            hold_r <= 1'b0;
            out_r <= flr_pkg::FLR_LANE_OUT_RST;
            oe_r <= flr_pkg::FLR_LANES_RELEASED;
            rx_valid_r <= 1'b0;
            rx_data_r <= flr_pkg::FLR_RX_DATA_RST;
            tx_take_r <= 1'b0;
            wp_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            hold_r <= hold_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            rx_valid_r <= rx_valid_nxt;
            rx_data_r <= rx_data_nxt;
            tx_take_r <= tx_take_nxt;
            wp_r <= wp_nxt;
            sel_r <= sel_nxt;
        end
    end

    assign o_lane_out = out_r;
    assign o_lane_oe_n = oe_r;
    assign o_rx_valid = rx_valid_r;
    assign o_rx_data = rx_data_r;
    assign o_tx_take = tx_take_r;
    assign o_write_protect = wp_r;
    assign o_hold_active = hold_r;
    assign o_selected = sel_r;

    // ********************************
    // assertions
    // ********************************
    a_deselect_release: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE14)
        pins.cs_n |=> (o_lane_oe_n == 4'hF) && !o_rx_valid)
        else $error("lanes driven or input taken while deselected");

    a_sample_on_rise: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE10)
        o_rx_valid |-> $past(pins.sck_rise) && !$past(hold_r))
        else $error("input sampled away from a rising clock edge");

    a_update_on_fall: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE11)
        (o_lane_out != $past(o_lane_out)) |-> $past(pins.sck_fall))
        else $error("output lanes changed away from a falling clock edge");

    a_single_out_lane: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE5)
        (state_r == flr_pkg::FLR_ST_OUT && !hold_r && mode_r == flr_pkg::FLR_SINGLE)
        |-> (o_lane_oe_n == 4'hD))
        else $error("single mode must drive lane 1 only");

    a_dual_out_lanes: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE7)
        (state_r == flr_pkg::FLR_ST_OUT && !hold_r && mode_r == flr_pkg::FLR_DUAL_OUT)
        |-> (o_lane_oe_n == 4'hC))
        else $error("dual output must drive lanes 0 and 1");

    a_quad_io_lanes: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE9)
        (state_r == flr_pkg::FLR_ST_OUT && !hold_r && mode_r == flr_pkg::FLR_QUAD_IO)
        |-> (o_lane_oe_n == 4'h0))
        else $error("quad io must drive all four lanes");

    a_hold_enter: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE15)
        (!pins.cs_n && !pins.sck_lvl && hold_req) |=> o_hold_active && (o_lane_oe_n == 4'hF))
        else $error("hold not taken while clock low");

    a_hold_release: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE4)
        hold_r |-> (o_lane_oe_n == 4'hF) && !o_rx_valid && !o_tx_take)
        else $error("lanes active during hold");

    a_wp_quad_off: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE13)
        i_quad_enable_bit |=> !o_write_protect)
        else $error("write protect active with quad enable set");

    a_no_idle_drive: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE17)
        (state_r != flr_pkg::FLR_ST_OUT) |-> (o_lane_oe_n == 4'hF))
        else $error("lanes driven outside the return phase");

    a_rx_single_lane: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE6)
        (o_rx_valid && $past(i_xfer_mode) != flr_pkg::FLR_DUAL_IO
        && $past(i_xfer_mode) != flr_pkg::FLR_QUAD_IO) |-> (o_rx_data[3:1] == 3'h0))
        else $error("host bits taken from a lane other than lane 0");

    a_take_on_fall: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE11)
        o_tx_take |-> $past(pins.sck_fall) && !o_hold_active)
        else $error("return data loaded away from a falling clock edge");

    a_quad_out_lanes: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE7)
        (state_r == flr_pkg::FLR_ST_OUT && !hold_r && mode_r == flr_pkg::FLR_QUAD_OUT)
        |-> (o_lane_oe_n == 4'h0))
        else $error("quad output must drive all four lanes");

    a_dual_io_lanes: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE9)
        (state_r == flr_pkg::FLR_ST_OUT && !hold_r && mode_r == flr_pkg::FLR_DUAL_IO)
        |-> (o_lane_oe_n == 4'hC))
        else $error("dual io must drive lanes 0 and 1");

    a_select_level: assert property (@(posedge i_ref_clk) disable iff (!rst_n_r) // see (RULE12)
        o_selected == !$past(pins.cs_n))
        else $error("select flag does not follow the low select pin");
endmodule : flr_lanes

// >>> flr_pkg.sv
// constants, types and decode functions for the multi-lane flash pin layer
// Contract
// (RULE1) lane 0 carries host bits in single mode, becomes data lane 0 otherwise
// (RULE2) lane 1 carries device bits in single mode, becomes data lane 1 otherwise
// (RULE3) write-protect pin acts as protect input unless quad operation is active
// (RULE4) hold pin pauses transfer in single or dual, is data lane 3 in quad
// (RULE5) single commands: host sends on lane 0 only, device answers on lane 1 only
// (RULE6) dual and quad output commands: host sends everything on lane 0 only
// (RULE7) dual output returns pairs on lanes 0-1, quad output nibbles on lanes 0-3
// (RULE8) dual and quad io commands: host sends pairs or nibbles on the wide lanes
// (RULE9) dual and quad io commands return data at the same lane width as input
// (RULE10) device samples every input lane at the serial clock rising edge
// (RULE11) device changes output bits only after a serial clock falling edge
// (RULE12) select, write-protect and hold are asserted when low
// (RULE13) quad enable bit set disables write-protect; pin is data lane 2 only
// (RULE14) select high: ignore all inputs and release every output lane; the code still lets the write-protect pin drive o_write_protect
// (RULE15) hold starts and ends only while clock is low; lanes released, inputs ignored
// (RULE16) host uses clock mode 0 or mode 3 while the memory is selected
// (RULE17) device drives lanes only during the data return phase
package flr_pkg;
    // ********************************
    // types
    // ********************************
    typedef enum logic [2:0] {
        FLR_SINGLE   = 3'b000,
        FLR_DUAL_OUT = 3'b001,
        FLR_QUAD_OUT = 3'b010,
        FLR_DUAL_IO  = 3'b011,
        FLR_QUAD_IO  = 3'b100
    } flr_mode_type;

    typedef enum logic [1:0] {
        FLR_ST_IDLE = 2'b00,
        FLR_ST_IN   = 2'b01,
        FLR_ST_OUT  = 2'b10
    } flr_state_type;

    // ********************************
    // constants
    // ********************************
    localparam logic [3:0] FLR_LANES_RELEASED = 4'hF;
    localparam logic [3:0] FLR_LANE_OUT_RST = 4'h0;
    localparam logic [3:0] FLR_RX_DATA_RST = 4'h0;
    localparam logic [3:0] FLR_MASK_LANE0 = 4'h1;
    localparam logic [3:0] FLR_MASK_LANE1 = 4'h2;
    localparam logic [3:0] FLR_MASK_PAIR = 4'h3;
    localparam logic [3:0] FLR_MASK_NIBBLE = 4'hF;
    localparam int FLR_SYNC_W = 6;
    localparam int FLR_SYNC_SCK_BIT = 0;
    localparam int FLR_SYNC_CS_BIT = 1;
    localparam int FLR_SYNC_LANE_LSB = 2;
    // pins idle: clock low, deselected, lanes 2 and 3 pulled high
    localparam logic [5:0] FLR_SYNC_RST = 6'h32;
    localparam logic [1:0] FLR_RST_SYNC_RST = 2'h0;

    // ********************************
    // decode functions
    // ********************************
    function automatic logic flr_is_quad(input flr_mode_type m);
        return (m == FLR_QUAD_OUT) || (m == FLR_QUAD_IO);
    endfunction : flr_is_quad

    function automatic logic [3:0] flr_out_mask(input flr_mode_type m);
        logic [3:0] r;
        r = FLR_MASK_LANE1;
        if (m == FLR_DUAL_OUT || m == FLR_DUAL_IO) begin
            r = FLR_MASK_PAIR;
        end else if (flr_is_quad(m)) begin
            r = FLR_MASK_NIBBLE;
        end
        return r;
    endfunction : flr_out_mask

    function automatic logic [3:0] flr_in_mask(input flr_mode_type m, input logic wide);
        logic [3:0] r;
        r = FLR_MASK_LANE0;
        if (wide && m == FLR_DUAL_IO) begin
            r = FLR_MASK_PAIR;
        end else if (wide && m == FLR_QUAD_IO) begin
            r = FLR_MASK_NIBBLE;
        end
        return r;
    endfunction : flr_in_mask
endpackage : flr_pkg

// >>> flr_pins_if.sv
// synchronised pin levels and serial clock edges
`timescale 1ns/1ps
interface flr_pins_if;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic cs_n;
    logic [3:0] lane_in;

    modport sync (output sck_lvl, output sck_rise, output sck_fall, output cs_n,
        output lane_in);
    modport ctrl (input sck_lvl, input sck_rise, input sck_fall, input cs_n,
        input lane_in);
endinterface : flr_pins_if

// >>> flr_pin_sync.sv
// two-flop synchroniser for the pins and serial clock edge finder
`timescale 1ns/1ps
module flr_pin_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_lane,
    flr_pins_if.sync pins
);
    logic [5:0] meta_r;
    logic [5:0] meta_nxt;
    logic [5:0] stab_r;
    logic [5:0] stab_nxt;
    logic sck_last_r;
    logic sck_last_nxt;

    always_comb begin
        meta_nxt = {i_lane, i_cs_n, i_sck};
        stab_nxt = meta_r;
        sck_last_nxt = stab_r[flr_pkg::FLR_SYNC_SCK_BIT];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= flr_pkg::FLR_SYNC_RST;
            stab_r <= flr_pkg::FLR_SYNC_RST;
            sck_last_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            stab_r <= stab_nxt;
            sck_last_r <= sck_last_nxt;
        end
    end

    assign pins.sck_lvl = stab_r[flr_pkg::FLR_SYNC_SCK_BIT];
    assign pins.sck_rise = stab_r[flr_pkg::FLR_SYNC_SCK_BIT] && !sck_last_r;
    assign pins.sck_fall = !stab_r[flr_pkg::FLR_SYNC_SCK_BIT] && sck_last_r;
    assign pins.cs_n = stab_r[flr_pkg::FLR_SYNC_CS_BIT];
    assign pins.lane_in = stab_r[flr_pkg::FLR_SYNC_LANE_LSB +: 4];
endmodule : flr_pin_sync

// >>> flr_lane_map.sv
// lane masks and placement of return data onto the lanes
`timescale 1ns/1ps
module flr_lane_map (
    input wire flr_pkg::flr_mode_type i_in_mode,
    input wire logic i_in_wide,
    input wire flr_pkg::flr_mode_type i_out_mode,
    input wire logic [3:0] i_tx_data,
    output logic [3:0] o_in_mask,
    output logic [3:0] o_out_mask,
    output logic [3:0] o_out_lanes
);
    always_comb begin
        o_in_mask = flr_pkg::flr_in_mask(i_in_mode, i_in_wide); // see (RULE8)
        o_out_mask = flr_pkg::flr_out_mask(i_out_mode);
        if (o_out_mask == flr_pkg::FLR_MASK_LANE1) begin
            o_out_lanes = {2'h0, i_tx_data[0], 1'b0}; // see (RULE5)
        end else begin
            o_out_lanes = i_tx_data & o_out_mask; // see (RULE7) see (RULE9)
        end
    end
endmodule : flr_lane_map

// >>> flr_host_model.sv
// host bus master model driving the serial clock, select and lanes
`timescale 1ns/1ps
module flr_host_model (
    input wire logic i_ref_clk,
    input wire logic [3:0] i_dev_out,
    input wire logic [3:0] i_dev_oe_n,
    output logic o_sck,
    output logic o_cs_n,
    output logic [3:0] o_lane
);
    logic [3:0] drv = 4'h0;
    logic [3:0] drv_en = 4'h0;
    logic tog = 1'b0;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
    end
    always @(posedge i_ref_clk) tog <= ~tog;
    // wire level: device, then host, then pull-up or a changing pattern
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_lane[i] = !i_dev_oe_n[i] ? i_dev_out[i] : drv_en[i] ? drv[i] : (i > 1) | (tog ^ (i == 1));
        end
    end
    // pin change at a fixed phase to the reference clock
    task automatic pins(input logic cs_n, input logic [3:0] v, input logic [3:0] en);
        @(posedge i_ref_clk);
        #3;
        o_cs_n = cs_n;
        drv = v;
        drv_en = en;
        #40;
    endtask : pins
    // hold a clock level for half a period
    task automatic step(input logic s, input logic [3:0] v);
        o_sck = s;
        drv = v;
        #40;
    endtask : step
    // one mode 0 period; lanes read just before the rising edge
    task automatic bit_cycle(input logic [3:0] v, input logic [3:0] en, output logic [3:0] seen);
        drv = v;
        drv_en = en;
        #39;
        seen = o_lane;
        #1;
        o_sck = 1'b1;
        #40;
        o_sck = 1'b0;
    endtask : bit_cycle
endmodule : flr_host_model

// >>> flr_lanes_tb_top.sv
// self-checking bench for the multi-lane flash pin layer
`timescale 1ns/1ps
module flr_lanes_tb_top;
    // ********************************
    // signals, design and host
    // ********************************
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic sck;
    logic cs_n;
    logic [3:0] lanes;
    flr_pkg::flr_mode_type i_xfer_mode = flr_pkg::FLR_SINGLE;
    logic i_in_wide = 1'b0;
    logic i_out_phase = 1'b0;
    logic i_quad_enable_bit = 1'b0;
    logic [3:0] i_tx_data = 4'h5;
    logic [3:0] o_lane_out;
    logic [3:0] o_lane_oe_n;
    logic o_rx_valid;
    logic [3:0] o_rx_data;
    logic o_tx_take;
    logic o_write_protect;
    logic o_hold_active;
    logic o_selected;
    int num_errors = 0;
    int n_compared = 0;
    logic [3:0] rxq[$];
    always #5 i_ref_clk = ~i_ref_clk;
    flr_lanes flr_lanes_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sck(sck),
        .i_cs_n(cs_n), .i_lane_in(lanes), .i_xfer_mode(i_xfer_mode), .i_in_wide(i_in_wide),
        .i_out_phase(i_out_phase), .i_quad_enable_bit(i_quad_enable_bit),
        .i_tx_data(i_tx_data), .o_lane_out(o_lane_out), .o_lane_oe_n(o_lane_oe_n),
        .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .o_tx_take(o_tx_take),
        .o_write_protect(o_write_protect), .o_hold_active(o_hold_active),
        .o_selected(o_selected));
    flr_host_model flr_host_model_inst (.i_ref_clk(i_ref_clk), .i_dev_out(o_lane_out),
        .i_dev_oe_n(o_lane_oe_n), .o_sck(sck), .o_cs_n(cs_n), .o_lane(lanes));
    always @(posedge i_ref_clk) if (o_rx_valid === 1'b1) rxq.push_back(o_rx_data);
    always @(posedge i_ref_clk) if (o_tx_take === 1'b1) i_tx_data <= i_tx_data + 4'h3;
    // ********************************
    // helpers
    // ********************************
    function automatic logic bad(input logic c);
        n_compared++;
        return c;
    endfunction : bad
    task automatic fail(input string msg);
        num_errors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail
    function automatic logic [3:0] out_mask(input flr_pkg::flr_mode_type m);
        if (m == flr_pkg::FLR_SINGLE) return 4'h2;
        if (m == flr_pkg::FLR_DUAL_OUT || m == flr_pkg::FLR_DUAL_IO) return 4'h3;
        return 4'hF;
    endfunction : out_mask
    function automatic logic [3:0] in_mask(input flr_pkg::flr_mode_type m);
        if (m == flr_pkg::FLR_DUAL_IO) return 4'h3;
        if (m == flr_pkg::FLR_QUAD_IO) return 4'hF;
        return 4'h1;
    endfunction : in_mask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // ********************************
    // scenarios
    // ********************************
    task automatic t_write(input flr_pkg::flr_mode_type m);
        logic [3:0] seen;
        logic [3:0] hi;
        int base;
        hi = (m == flr_pkg::FLR_QUAD_IO) ? 4'h0 : 4'hC;
        @(posedge i_ref_clk);
        i_xfer_mode <= m;
        i_in_wide <= (m != flr_pkg::FLR_SINGLE);
        i_out_phase <= 1'b0;
        flr_host_model_inst.pins(1'b0, 4'hF, 4'hF);
        base = rxq.size();
        for (int k = 0; k < 4; k++) flr_host_model_inst.bit_cycle(4'(6 + 5 * k) | hi, 4'hF, seen);
        flr_host_model_inst.pins(1'b1, 4'hF, 4'hD);
        if (bad(rxq.size() !== base + 4)) fail("write sample count");
        for (int k = 0; k < 4; k++) begin
            if (bad(rxq[base + k] !== ((4'(6 + 5 * k) | hi) & in_mask(m)))) fail("write lanes");
        end
        $display("write test mode %0d done", m);
    endtask : t_write
    task automatic t_read(input flr_pkg::flr_mode_type m);
        logic [3:0] seen;
        logic [3:0] en;
        logic [3:0] v;
        logic [3:0] exp;
        en = (m == flr_pkg::FLR_QUAD_OUT || m == flr_pkg::FLR_QUAD_IO) ? 4'h0 : 4'hC;
        @(posedge i_ref_clk);
        i_xfer_mode <= m;
        i_in_wide <= (m == flr_pkg::FLR_DUAL_IO || m == flr_pkg::FLR_QUAD_IO);
        i_out_phase <= 1'b1;
        i_tx_data <= 4'h5;
        flr_host_model_inst.pins(1'b0, 4'hD, en | 4'h1);
        flr_host_model_inst.bit_cycle(4'hD, en | 4'h1, seen);
        v = 4'h5;
        for (int k = 0; k < 5; k++) begin
            flr_host_model_inst.bit_cycle(4'hC, en, seen);
            exp = (m == flr_pkg::FLR_SINGLE) ? {2'b00, v[0], 1'b0} : (v & out_mask(m));
            if (bad((seen & out_mask(m)) !== exp)) fail("return data");
            if (bad(o_lane_oe_n !== ~out_mask(m))) fail("return lanes");
            v = v + 4'h3;
        end
        flr_host_model_inst.pins(1'b1, 4'hF, 4'hD);
        repeat (6) @(posedge i_ref_clk);
        if (bad(o_lane_oe_n !== 4'hF || o_selected !== 1'b0)) fail("not released");
        i_out_phase <= 1'b0;
        $display("read test mode %0d done", m);
    endtask : t_read
    task automatic t_pin_roles();
        logic [7:0] tbl [5] = '{8'h0A, 8'h13, 8'h80, 8'h40, 8'h3C};
        for (int i = 0; i < 5; i++) begin
            @(posedge i_ref_clk);
            i_quad_enable_bit <= tbl[i][7];
            i_xfer_mode <= flr_pkg::flr_mode_type'(tbl[i][6:4]);
            flr_host_model_inst.pins(1'b0, {tbl[i][3:2], 2'b01}, 4'hD);
            repeat (8) @(posedge i_ref_clk);
            if (bad(o_write_protect !== tbl[i][1])) fail("write protect");
            if (bad(o_hold_active !== tbl[i][0])) fail("hold level");
        end
        flr_host_model_inst.pins(1'b1, 4'hF, 4'hD);
        $display("pin role test done");
    endtask : t_pin_roles
    task automatic t_hold();
        int base;
        @(posedge i_ref_clk);
        i_quad_enable_bit <= 1'b0;
        i_xfer_mode <= flr_pkg::FLR_SINGLE;
        flr_host_model_inst.pins(1'b0, 4'hD, 4'hD);
        flr_host_model_inst.step(1'b1, 4'hD);
        flr_host_model_inst.step(1'b1, 4'h5);
        if (bad(o_hold_active !== 1'b0)) fail("hold while clock high");
        base = rxq.size();
        flr_host_model_inst.step(1'b0, 4'h5);
        if (bad(o_hold_active !== 1'b1)) fail("hold at clock low");
        flr_host_model_inst.step(1'b1, 4'h5);
        flr_host_model_inst.step(1'b0, 4'h5);
        flr_host_model_inst.step(1'b1, 4'h4);
        flr_host_model_inst.step(1'b1, 4'hD);
        if (bad(rxq.size() !== base)) fail("sampled in hold");
        if (bad(o_hold_active !== 1'b1)) fail("hold ended early");
        flr_host_model_inst.step(1'b0, 4'hD);
        if (bad(o_hold_active !== 1'b0)) fail("hold not ended");
        flr_host_model_inst.pins(1'b1, 4'hF, 4'hD);
        $display("hold test done");
    endtask : t_hold
    task automatic t_deselect();
        logic [3:0] seen;
        int base;
        @(posedge i_ref_clk);
        i_xfer_mode <= flr_pkg::FLR_QUAD_OUT;
        i_out_phase <= 1'b1;
        flr_host_model_inst.pins(1'b1, 4'h3, 4'hF);
        base = rxq.size();
        for (int k = 0; k < 3; k++) flr_host_model_inst.bit_cycle(4'h3, 4'hF, seen);
        if (bad(rxq.size() !== base || o_lane_oe_n !== 4'hF)) fail("active deselected");
        @(posedge i_ref_clk);
        i_out_phase <= 1'b0;
        $display("deselect test done");
    endtask : t_deselect
    // ********************************
    // main sequence and watchdog
    // ********************************
    initial begin
        repeat (8) @(posedge i_ref_clk);
        if (bad(o_lane_oe_n !== 4'hF)) fail("lanes driven in reset");
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        t_write(flr_pkg::FLR_SINGLE);
        t_write(flr_pkg::FLR_DUAL_IO);
        t_write(flr_pkg::FLR_QUAD_IO);
        for (int i = 0; i < 5; i++) t_read(flr_pkg::flr_mode_type'(3'(i)));
        t_pin_roles();
        t_hold();
        t_deselect();
        tally_and_finish();
    end
    initial begin
        #100000;
        fail("watchdog expired");
        tally_and_finish();
    end
endmodule : flr_lanes_tb_top
